//--- csbu_core.sv
// Compare, skip and conditional branch execution unit
`timescale 1ns/1ns
module csbu_core (
    // Clock and reset
    input  wire logic                              clk_in,
    input  wire logic                              rst_in,
    // Instruction issue
    input  wire logic                              issue_in,
    input  wire csbu_pkg::csbu_op_t                op_in,
    input  wire logic [7:0]                        reg_a_in,
    input  wire logic [7:0]                        reg_b_in,
    input  wire logic [7:0]                        imm_in,
    input  wire logic [7:0]                        io_in,
    input  wire logic [2:0]                        bit_sel_in,
    input  wire logic [csbu_pkg::CSBU_OFS_W-1:0]   offset_in,
    input  wire logic                              next_long_in,
    input  wire logic [csbu_pkg::CSBU_PC_W-1:0]    pc_in,
    // Flag register
    input  wire logic [7:0]                        flags_in,
    output logic [7:0]                             flags_out,
    output logic                                   flags_we_out,
    // Program counter and busy status
    output logic [csbu_pkg::CSBU_PC_W-1:0]         pc_out,
    output logic                                   pc_we_out,
    output logic                                   busy_out
);
    import csbu_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [CSBU_PC_W-1:0] sext_ofs(input logic [CSBU_OFS_W-1:0] o);
        sext_ofs = {{(CSBU_PC_W-CSBU_OFS_W){o[CSBU_OFS_W-1]}}, o};
    endfunction

    function automatic logic [CSBU_PC_W-1:0] pc_add(input logic [CSBU_PC_W-1:0] p,
                                                    input logic [1:0] n);
        pc_add = p + {{(CSBU_PC_W-2){1'b0}}, n};
    endfunction

    typedef enum logic [1:0] {
        CSBU_ST_IDLE = 2'b01,
        CSBU_ST_WAIT = 2'b10
    } csbu_state_t;

    csbu_state_t  state_r;
    logic [1:0]   wait_r;
    logic         is_cmp;
    logic         is_skip;
    logic         is_br;
    logic         cond;
    logic [7:0]   rhs;
    logic         borrow;
    logic         z_c;
    logic         n_c;
    logic         v_c;
    logic         c_c;
    logic         h_c;
    logic         go;

    // ------------------------------------------------------------
    // Decode and condition
    // ------------------------------------------------------------
    always_comb begin
        is_cmp  = 1'b0;
        is_skip = 1'b0;
        is_br   = 1'b0;
        cond    = 1'b0;
        rhs     = reg_b_in;
        borrow  = 1'b0;
        case (op_in)
            CSBU_OP_COMPARE_REGS: begin
                is_cmp = 1'b1;
            end
            CSBU_OP_COMPARE_REGS_WITH_CARRY: begin
                is_cmp = 1'b1;
                borrow = flags_in[CSBU_FLAG_C];
            end
            CSBU_OP_COMPARE_IMMEDIATE: begin
                is_cmp = 1'b1;
                rhs    = imm_in;
            end
            CSBU_OP_SKIP_IF_REG_BIT_CLEAR: begin
                is_skip = 1'b1;
                cond    = ~reg_a_in[bit_sel_in];
            end
            CSBU_OP_SKIP_IF_REG_BIT_SET: begin
                is_skip = 1'b1;
                cond    = reg_a_in[bit_sel_in];
            end
            CSBU_OP_SKIP_IF_IO_BIT_CLEAR: begin
                is_skip = 1'b1;
                cond    = ~io_in[bit_sel_in];
            end
            CSBU_OP_SKIP_IF_IO_BIT_SET: begin
                is_skip = 1'b1;
                cond    = io_in[bit_sel_in];
            end
            CSBU_OP_BRANCH_IF_FLAG_SET: begin
                is_br = 1'b1;
                cond  = flags_in[bit_sel_in];
            end
            CSBU_OP_BRANCH_IF_FLAG_CLEAR: begin
                is_br = 1'b1;
                cond  = ~flags_in[bit_sel_in];
            end
            CSBU_OP_BRANCH_IF_EQUAL: begin
                is_br = 1'b1;
                cond  = flags_in[CSBU_FLAG_Z];
            end
            CSBU_OP_BRANCH_IF_NOT_EQUAL: begin
                is_br = 1'b1;
                cond  = ~flags_in[CSBU_FLAG_Z];
            end
            CSBU_OP_BRANCH_IF_CARRY_SET: begin
                is_br = 1'b1;
                cond  = flags_in[CSBU_FLAG_C];
            end
            CSBU_OP_BRANCH_IF_CARRY_CLEAR,
            CSBU_OP_BRANCH_IF_SAME_OR_HIGHER: begin
                is_br = 1'b1;
                cond  = ~flags_in[CSBU_FLAG_C];
            end
            default: begin
                is_cmp = 1'b0;
            end
        endcase
    end

    assign go = issue_in && (state_r == CSBU_ST_IDLE);

    // ------------------------------------------------------------
    // Compare arithmetic
    // ------------------------------------------------------------
    csbu_flag_calc u_calc (
        .lhs_in     (reg_a_in),
        .rhs_in     (rhs),
        .borrow_in  (borrow),
        .chain_z_in (op_in == CSBU_OP_COMPARE_REGS_WITH_CARRY ? flags_in[CSBU_FLAG_Z] : 1'b1),
        .z_out      (z_c),
        .n_out      (n_c),
        .v_out      (v_c),
        .c_out      (c_c),
        .h_out      (h_c)
    );

    // ------------------------------------------------------------
    // Flag update, one cycle
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            flags_out    <= CSBU_FLAGS_RST;
            flags_we_out <= 1'b0;
        end else begin
            flags_we_out <= go && is_cmp;
            if (go && is_cmp) begin
                flags_out              <= flags_in;
                flags_out[CSBU_FLAG_Z] <= z_c;
                flags_out[CSBU_FLAG_N] <= n_c;
                flags_out[CSBU_FLAG_V] <= v_c;
                flags_out[CSBU_FLAG_C] <= c_c;
                flags_out[CSBU_FLAG_H] <= h_c;
                flags_out[CSBU_FLAG_S] <= n_c ^ v_c;
            end
        end
    end

    // ------------------------------------------------------------
    // Program counter update
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pc_out    <= CSBU_PC_RST;
            pc_we_out <= 1'b0;
        end else begin
            pc_we_out <= go && cond && (is_skip || is_br);
            if (go && cond && is_skip) begin
                pc_out <= pc_add(pc_in, next_long_in ? CSBU_SKIP_LONG : CSBU_SKIP_SHORT);
            end else if (go && cond && is_br) begin
                pc_out <= pc_in + sext_ofs(offset_in) + {{(CSBU_PC_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // ------------------------------------------------------------
    // Cycle count: extra wait cycles for taken skip or branch
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= CSBU_ST_IDLE;
            wait_r  <= 2'h0;
        end else begin
            case (state_r)
                CSBU_ST_IDLE: begin
                    if (go && cond && is_br) begin
                        state_r <= CSBU_ST_WAIT;
                        wait_r  <= CSBU_TAKEN_WAIT;
                    end else if (go && cond && is_skip) begin
                        state_r <= CSBU_ST_WAIT;
                        wait_r  <= next_long_in ? 2'h2 : 2'h1;
                    end
                end
                CSBU_ST_WAIT: begin
                    wait_r <= wait_r - 2'h1;
                    if (wait_r == 2'h1) begin
                        state_r <= CSBU_ST_IDLE;
                    end
                end
                default: begin
                    state_r <= CSBU_ST_IDLE;
                end
            endcase
        end
    end

    assign busy_out = (state_r != CSBU_ST_IDLE);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence taken_br_s;
        go && is_br && cond;
    endsequence

    sequence taken_skip_s;
        go && is_skip && cond;
    endsequence

    cmp_flags_a: assert property (@(posedge clk_in) disable iff (rst_in)
        go && is_cmp |=> flags_we_out && flags_out[CSBU_FLAG_Z] == $past(z_c)
                         && !pc_we_out && !busy_out)
        else $error("compare did not update flags in one cycle");

    cmp_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
        go && op_in == CSBU_OP_COMPARE_REGS && reg_a_in == reg_b_in
        |=> flags_out[CSBU_FLAG_Z] && !flags_out[CSBU_FLAG_C])
        else $error("equal compare gave wrong flags");

    skip_target_a: assert property (@(posedge clk_in) disable iff (rst_in)
        taken_skip_s |=> pc_we_out && !flags_we_out
                         && pc_out == $past(pc_in) + ($past(next_long_in) ? 16'h0003 : 16'h0002))
        else $error("skip target wrong");

    skip_busy_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (taken_skip_s and !next_long_in) |=> busy_out ##1 !busy_out)
        else $error("short skip cycle count wrong");

    br_target_a: assert property (@(posedge clk_in) disable iff (rst_in)
        taken_br_s |=> pc_we_out && !flags_we_out && pc_out == $past(pc_in)
                       + {{9{$past(offset_in[6])}}, $past(offset_in)} + 16'h0001)
        else $error("branch target wrong");

    br_cycles_a: assert property (@(posedge clk_in) disable iff (rst_in)
        taken_br_s |=> busy_out ##1 !busy_out)
        else $error("taken branch not two cycles");

    eq_cond_a: assert property (@(posedge clk_in) disable iff (rst_in)
        go && op_in == CSBU_OP_BRANCH_IF_NOT_EQUAL && flags_in[CSBU_FLAG_Z] |=> !pc_we_out)
        else $error("not-equal branch taken on zero");

    same_high_a: assert property (@(posedge clk_in) disable iff (rst_in)
        go && op_in == CSBU_OP_BRANCH_IF_SAME_OR_HIGHER |=> pc_we_out == !$past(flags_in[0]))
        else $error("same-or-higher branch differs from carry-clear");
endmodule

//--- csbu_pkg.sv
// Package for the compare, skip and branch unit
package csbu_pkg;
    // ------------------------------------------------------------
    // Operation codes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        CSBU_OP_NONE                     = 4'h0,
        CSBU_OP_COMPARE_REGS             = 4'h1,
        CSBU_OP_COMPARE_REGS_WITH_CARRY  = 4'h2,
        CSBU_OP_COMPARE_IMMEDIATE        = 4'h3,
        CSBU_OP_SKIP_IF_REG_BIT_CLEAR    = 4'h4,
        CSBU_OP_SKIP_IF_REG_BIT_SET      = 4'h5,
        CSBU_OP_SKIP_IF_IO_BIT_CLEAR     = 4'h6,
        CSBU_OP_SKIP_IF_IO_BIT_SET       = 4'h7,
        CSBU_OP_BRANCH_IF_FLAG_SET       = 4'h8,
        CSBU_OP_BRANCH_IF_FLAG_CLEAR     = 4'h9,
        CSBU_OP_BRANCH_IF_EQUAL          = 4'ha,
        CSBU_OP_BRANCH_IF_NOT_EQUAL      = 4'hb,
        CSBU_OP_BRANCH_IF_CARRY_SET      = 4'hc,
        CSBU_OP_BRANCH_IF_CARRY_CLEAR    = 4'hd,
        CSBU_OP_BRANCH_IF_SAME_OR_HIGHER = 4'he
    } csbu_op_t;

    // ------------------------------------------------------------
    // Flag register bit positions
    // ------------------------------------------------------------
    localparam int CSBU_FLAG_C = 0;
    localparam int CSBU_FLAG_Z = 1;
    localparam int CSBU_FLAG_N = 2;
    localparam int CSBU_FLAG_V = 3;
    localparam int CSBU_FLAG_S = 4;
    localparam int CSBU_FLAG_H = 5;

    // ------------------------------------------------------------
    // Widths, reset values and counts
    // ------------------------------------------------------------
    localparam int         CSBU_PC_W        = 16;
    localparam int         CSBU_OFS_W       = 7;
    localparam logic [7:0] CSBU_FLAGS_RST   = 8'h00;
    localparam logic [15:0] CSBU_PC_RST     = 16'h0000;
    localparam logic [1:0] CSBU_SKIP_SHORT  = 2'h2;
    localparam logic [1:0] CSBU_SKIP_LONG   = 2'h3;
    localparam logic [1:0] CSBU_TAKEN_WAIT  = 2'h1;
endpackage

//--- csbu_flag_calc.sv
// Subtract-and-flag calculator for compares
`timescale 1ns/1ns
module csbu_flag_calc (
    // Operands
    input  wire logic [7:0] lhs_in,
    input  wire logic [7:0] rhs_in,
    input  wire logic       borrow_in,
    input  wire logic       chain_z_in,
    // Flags
    output logic            z_out,
    output logic            n_out,
    output logic            v_out,
    output logic            c_out,
    output logic            h_out
);
    logic [7:0] diff;

    always_comb begin
        diff  = lhs_in - rhs_in - {7'h00, borrow_in};
        n_out = diff[7];
        z_out = (diff == 8'h00) && chain_z_in;
        c_out = (~lhs_in[7] & rhs_in[7]) | (rhs_in[7] & diff[7]) | (diff[7] & ~lhs_in[7]);
        h_out = (~lhs_in[3] & rhs_in[3]) | (rhs_in[3] & diff[3]) | (diff[3] & ~lhs_in[3]);
        v_out = (lhs_in[7] & ~rhs_in[7] & ~diff[7]) | (~lhs_in[7] & rhs_in[7] & diff[7]);
    end
endmodule

//--- tb_compare_skip_branch_unit.sv
// Testbench for the compare, skip and branch unit
`timescale 1ns/1ns
module tb_compare_skip_branch_unit;
    import csbu_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and design outputs
    // ------------------------------------------------------------
    localparam logic [15:0] PC0 = 16'h8000;
    logic        clk_in       = 1'b0;
    logic        rst_in       = 1'b1;
    logic        issue_in     = 1'b0;
    csbu_op_t    op_in        = CSBU_OP_NONE;
    logic [7:0]  reg_a_in     = 8'h00;
    logic [7:0]  reg_b_in     = 8'h00;
    logic [7:0]  imm_in       = 8'h00;
    logic [7:0]  io_in        = 8'h00;
    logic [2:0]  bit_sel_in   = 3'h0;
    logic [6:0]  offset_in    = 7'h00;
    logic        next_long_in = 1'b0;
    logic [15:0] pc_in        = 16'h0000;
    logic [7:0]  flags_in     = 8'h00;
    logic [7:0]  flags_out;
    logic        flags_we_out;
    logic [15:0] pc_out;
    logic        pc_we_out;
    logic        busy_out;
    int          n_errors     = 0;
    int          compares     = 0;
    int          cycles       = 0;

    always #4 clk_in = ~clk_in;

    csbu_core dut_u (
        .clk_in(clk_in), .rst_in(rst_in), .issue_in(issue_in), .op_in(op_in),
        .reg_a_in(reg_a_in), .reg_b_in(reg_b_in), .imm_in(imm_in), .io_in(io_in),
        .bit_sel_in(bit_sel_in), .offset_in(offset_in), .next_long_in(next_long_in),
        .pc_in(pc_in), .flags_in(flags_in), .flags_out(flags_out),
        .flags_we_out(flags_we_out), .pc_out(pc_out), .pc_we_out(pc_we_out),
        .busy_out(busy_out)
    );

    // ------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------
    task automatic summarize();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_flags(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_pc(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // Expected flags of a subtract without result
    // ------------------------------------------------------------
    function automatic logic [7:0] cmp_flags(input logic [7:0] a, input logic [7:0] b,
                                             input logic wc, input logic [7:0] f);
        logic [7:0] r;
        logic [7:0] e;
        r = a - b - {7'h00, wc & f[CSBU_FLAG_C]};
        e = f;
        e[CSBU_FLAG_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
        e[CSBU_FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
        e[CSBU_FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        e[CSBU_FLAG_N] = r[7];
        e[CSBU_FLAG_S] = e[CSBU_FLAG_N] ^ e[CSBU_FLAG_V];
        e[CSBU_FLAG_Z] = (r == 8'h00) & (~wc | f[CSBU_FLAG_Z]);
        return e;
    endfunction

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic run_cmp(input csbu_op_t op, input logic [7:0] a, input logic [7:0] b,
                           input logic [7:0] f);
        @(posedge clk_in);
        reg_a_in <= a;
        reg_b_in <= (op == CSBU_OP_COMPARE_IMMEDIATE) ? ~b : b;
        imm_in   <= (op == CSBU_OP_COMPARE_IMMEDIATE) ? b : ~b;
        flags_in <= f;
        op_in    <= op;
        issue_in <= 1'b1;
        @(posedge clk_in);
        issue_in <= 1'b0;
        #1;
        chk_bit("flags_we", 1'b1, flags_we_out);
        chk_bit("pc_we", 1'b0, pc_we_out);
        chk_flags("flags", cmp_flags(a, b, op == CSBU_OP_COMPARE_REGS_WITH_CARRY, f), flags_out);
    endtask

    task automatic run_ctl(input csbu_op_t op, input logic [7:0] a, input logic [2:0] sel,
                           input logic [6:0] ofs, input logic lng, input logic [7:0] f,
                           input logic take, input logic [15:0] tgt, input int waits);
        @(posedge clk_in);
        reg_a_in     <= (op[3:1] == 3'h3) ? ~a : a;
        io_in        <= (op[3:1] == 3'h3) ? a : ~a;
        bit_sel_in   <= sel;
        offset_in    <= ofs;
        next_long_in <= lng;
        flags_in     <= f;
        pc_in        <= PC0;
        op_in        <= op;
        issue_in     <= 1'b1;
        @(posedge clk_in);
        issue_in <= 1'b0;
        #1;
        chk_bit("pc_we", take, pc_we_out);
        chk_bit("flags_we", 1'b0, flags_we_out);
        if (take) begin
            chk_pc("pc", tgt, pc_out);
        end
        for (int i = 0; i <= waits; i++) begin
            chk_bit("busy", take && i < waits, busy_out);
            @(posedge clk_in);
            #1;
        end
    endtask

    task automatic run_refuse();
        @(posedge clk_in);
        flags_in  <= 8'h02;
        offset_in <= 7'h05;
        pc_in     <= PC0;
        op_in     <= CSBU_OP_BRANCH_IF_EQUAL;
        issue_in  <= 1'b1;
        @(posedge clk_in);
        op_in <= CSBU_OP_COMPARE_REGS;
        @(posedge clk_in);
        issue_in <= 1'b0;
        #1;
        chk_bit("busy_refuse", 1'b0, busy_out);
        chk_bit("flags_we_refuse", 1'b0, flags_we_out);
        chk_pc("pc_refuse", PC0 + 16'h0006, pc_out);
        @(posedge clk_in);
        #1;
        chk_bit("pc_we_refuse", 1'b0, pc_we_out);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        static logic [7:0] av [5] = '{8'h10, 8'h20, 8'h80, 8'h7f, 8'h00};
        static logic [7:0] bv [5] = '{8'h20, 8'h20, 8'h01, 8'hff, 8'h00};
        static logic [7:0] fv [2] = '{8'h00, 8'hc3};
        static int         ix [5] = '{1, 1, 0, 0, 0};
        static logic       pv [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        static logic [7:0] m;
        static logic [6:0] o;
        repeat (16) @(posedge clk_in);
        chk_flags("flags_rst", CSBU_FLAGS_RST, flags_out);
        chk_pc("pc_rst", CSBU_PC_RST, pc_out);
        chk_bit("busy_rst", 1'b0, busy_out);
        rst_in <= 1'b0;
        foreach (av[i]) begin
            for (int k = 1; k <= 3; k++) begin
                for (int j = 0; j < 2; j++) begin
                    run_cmp(csbu_op_t'(k), av[i], bv[i], fv[j]);
                end
            end
        end
        for (int k = 4; k <= 7; k++) begin
            for (int j = 0; j < 4; j++) begin
                m = 8'h01 << 3'(k + 3 * j);
                run_ctl(csbu_op_t'(k), j[0] ? m : ~m, 3'(k + 3 * j), 7'h00, j[1], 8'h3f,
                        j[0] == k[0], PC0 + (j[1] ? 16'h0003 : 16'h0002), j[1] ? 2 : 1);
            end
        end
        for (int s = 0; s < 8; s++) begin
            for (int k = 8; k <= 9; k++) begin
                for (int j = 0; j < 2; j++) begin
                    m = 8'h01 << s;
                    o = j[0] ? 7'h3f : 7'h40;
                    run_ctl(csbu_op_t'(k), 8'h00, 3'(s), o, 1'b0, j[0] ? m : ~m,
                            j[0] != k[0], PC0 + {{9{o[6]}}, o} + 16'h0001, 1);
                end
            end
        end
        foreach (ix[i]) begin
            for (int j = 0; j < 2; j++) begin
                m = 8'h01 << ix[i];
                run_ctl(csbu_op_t'(10 + i), 8'h00, 3'h7, 7'h7e, 1'b0, j[0] ? m : ~m,
                        j[0] == pv[i], PC0 - 16'h0001, 1);
            end
        end
        run_ctl(CSBU_OP_BRANCH_IF_SAME_OR_HIGHER, 8'h00, 3'h0, 7'h01, 1'b0, 8'hfe,
                1'b1, PC0 + 16'h0002, 1);
        run_ctl(CSBU_OP_NONE, 8'hff, 3'h0, 7'h01, 1'b0, 8'hff, 1'b0, PC0, 0);
        run_refuse();
        summarize();
    end
endmodule
